//--- uld_pkg.sv
// Package for the USB link power and descriptor default block.
// Assumes a 32-bit APB register bus and a byte-wide descriptor read port.
package uld_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CFG0    = 8'h00;
  localparam logic [7:0] OFS_PMCTL   = 8'h04;
  localparam logic [7:0] OFS_NVSTAT  = 8'h08;
  localparam logic [7:0] OFS_LINK    = 8'h0c;
  localparam logic [7:0] OFS_IDS     = 8'h10;
  localparam logic [7:0] OFS_DEV0    = 8'h14;
  localparam logic [7:0] OFS_DEV1    = 8'h18;
  localparam logic [7:0] OFS_DEV2    = 8'h1c;
  localparam logic [7:0] OFS_CFGD    = 8'h20;
  localparam logic [7:0] OFS_TLEN    = 8'h24;

  // ----------------------------------------
  // Bit positions in usb_config_reg_zero and in the configuration attributes byte
  // ----------------------------------------
  localparam int B_LINK_PM_CAPABILITY_BIT  = 0;
  localparam int B_RMT_WKP  = 1;
  localparam int B_SELF_PWR = 2;
  localparam int B_CUST_EN  = 3;
  localparam int B_ATTR_SP  = 6;
  localparam int B_ATTR_RW  = 5;

  // ----------------------------------------
  // Fixed and default descriptor values
  // ----------------------------------------
  localparam logic [7:0]  DEV_LEN      = 8'h12;
  localparam logic [7:0]  DEV_TYPE     = 8'h01;
  localparam logic [7:0]  CFG_TYPE     = 8'h02;
  localparam logic [7:0]  CFG_LEN      = 8'h09;
  localparam logic [15:0] BCD_USB2     = 16'h0210;
  localparam logic [15:0] BCD_USB3     = 16'h0300;
  localparam logic [7:0]  MPS0_SS      = 8'h09;
  localparam logic [7:0]  MPS0_HS      = 8'h40;
  localparam logic [7:0]  DEF_CLASS    = 8'hff;
  localparam logic [7:0]  DEF_SUBCLASS = 8'h00;
  localparam logic [7:0]  DEF_PROTO    = 8'hff;
  localparam logic [7:0]  DEF_STRIDX   = 8'h00;
  localparam logic [7:0]  DEF_ONE      = 8'h01;
  localparam logic [7:0]  BCD_DEV_LSB  = 8'h00;
  localparam logic [15:0] TLEN_USB2    = 16'h0027;
  localparam logic [15:0] TLEN_USB3    = 16'h0039;
  localparam logic [7:0]  DEF_ATTR     = 8'he0;
  localparam logic [7:0]  PWR_SELF     = 8'h01;
  localparam logic [7:0]  PWR_BUS2     = 8'hfa;
  localparam logic [7:0]  PWR_BUS3     = 8'h70;
  localparam logic [7:0]  ZERO8        = 8'h00;

  typedef enum logic [1:0] {
    SPD_FS = 2'b00,
    SPD_HS = 2'b01,
    SPD_SS = 2'b10
  } uld_speed_e;

  typedef enum logic [1:0] {
    LNK_L0 = 2'b00,
    LNK_L1 = 2'b01,
    LNK_L2 = 2'b10
  } uld_link_e;

  // Descriptor image written by the nonvolatile loader
  typedef struct packed {
    logic [15:0] vid;
    logic [15:0] pid;
    logic [15:0] bcd_usb;
    logic [7:0]  dclass;
    logic [7:0]  dsub;
    logic [7:0]  dproto;
    logic [7:0]  mps0;
    logic [7:0]  imfr;
    logic [7:0]  iprod;
    logic [7:0]  iser;
    logic [7:0]  ncfg;
    logic [7:0]  clen;
    logic [7:0]  nif;
    logic [7:0]  cval;
    logic [7:0]  icfg;
    logic [7:0]  attr;
    logic [7:0]  maxpwr;
    logic [15:0] tlen;
  } uld_img_s;

  // Descriptor byte request from the USB protocol engine
  typedef struct packed {
    logic       valid;
    logic       is_cfg;
    logic [4:0] idx;
  } uld_req_s;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } uld_rsp_s;

endpackage

//--- uld_desc_mux.sv
// Descriptor byte selector: merges loaded image with defaults.
// Assumes speed and config flags are stable in the request cycle.
`timescale 1ns/1ps
module uld_desc_mux
  import uld_pkg::*;
#(
  parameter logic [7:0] SILICON_REV = 8'h01
)(
  input  wire uld_img_s   img,
  input  wire logic       use_def,
  input  wire uld_speed_e speed,
  input  wire logic       self_pwr,
  input  wire logic       rmt_wkp,
  input  wire logic       is_cfg,
  input  wire logic [4:0] idx,
  output logic [7:0]      data,
  output logic            err
);

  wire       ss = (speed == SPD_SS);
  wire [15:0] bcdusb = use_def ? (ss ? BCD_USB3 : BCD_USB2) : img.bcd_usb;
  wire [7:0]  mps0   = ss ? MPS0_SS : MPS0_HS;
  wire [15:0] tlen   = use_def ? (ss ? TLEN_USB3 : TLEN_USB2) : img.tlen;
  wire [7:0]  defpwr = self_pwr ? PWR_SELF : (ss ? PWR_BUS3 : PWR_BUS2);
  wire [7:0]  maxpwr = use_def ? defpwr : img.maxpwr;
  wire [7:0]  defatt = (DEF_ATTR & ~8'h60) | ({7'h00, self_pwr} << B_ATTR_SP)
                       | ({7'h00, rmt_wkp} << B_ATTR_RW);
  wire [7:0]  attr   = use_def ? defatt : img.attr;

  // Device descriptor is 18 bytes; byte 7 and default bytes 2-3 depend on speed
  wire [7:0] dev [18];
  assign dev[0]  = DEV_LEN;
  assign dev[1]  = DEV_TYPE;
  assign dev[2]  = bcdusb[7:0];
  assign dev[3]  = bcdusb[15:8];
  assign dev[4]  = use_def ? DEF_CLASS    : img.dclass;
  assign dev[5]  = use_def ? DEF_SUBCLASS : img.dsub;
  assign dev[6]  = use_def ? DEF_PROTO    : img.dproto;
  assign dev[7]  = mps0;
  assign dev[8]  = img.vid[7:0];
  assign dev[9]  = img.vid[15:8];
  assign dev[10] = img.pid[7:0];
  assign dev[11] = img.pid[15:8];
  assign dev[12] = BCD_DEV_LSB;
  assign dev[13] = SILICON_REV;
  assign dev[14] = use_def ? DEF_STRIDX : img.imfr;
  assign dev[15] = use_def ? DEF_STRIDX : img.iprod;
  assign dev[16] = use_def ? DEF_STRIDX : img.iser;
  assign dev[17] = use_def ? DEF_ONE    : img.ncfg;

  // Configuration descriptor is 9 bytes
  wire [7:0] cfg [9];
  assign cfg[0] = use_def ? CFG_LEN : img.clen;
  assign cfg[1] = CFG_TYPE;
  assign cfg[2] = tlen[7:0];
  assign cfg[3] = tlen[15:8];
  assign cfg[4] = use_def ? DEF_ONE : img.nif;
  assign cfg[5] = use_def ? DEF_ONE : img.cval;
  assign cfg[6] = use_def ? DEF_STRIDX : img.icfg;
  assign cfg[7] = attr;
  assign cfg[8] = maxpwr;

  wire dev_oob = (idx > 5'd17);
  wire cfg_oob = (idx > 5'd8);
  assign err  = is_cfg ? cfg_oob : dev_oob;
  assign data = err ? ZERO8 : (is_cfg ? cfg[idx[3:0]] : dev[idx]);

endmodule

//--- uld_top.sv
// USB link power management (L0/L1/L2) and descriptor defaults.
// Assumes APB from software, pulses from the link layer, filter engine
// and interrupt endpoint scheduler, all synchronous to pclk.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module uld_top
  import uld_pkg::*;
#(
  parameter logic [15:0] DEF_VID     = 16'h1234,  // Arbitrary value
  parameter logic [15:0] DEF_PID     = 16'h5678,  // Arbitrary value
  parameter logic [7:0]  SILICON_REV = 8'h01,
  parameter int          SUSP_W      = 2
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire uld_speed_e        bus_speed,
  input  wire logic              lpm_l1_req,
  input  wire logic              suspend_req,
  input  wire logic              host_resume,
  input  wire logic              rx_frame_pass,
  input  wire logic              intr_ep_sched,
  output logic                   lpm_ack,
  output logic                   lpm_nyet,
  output logic                   remote_wake,
  output uld_link_e              link_state,
  output logic                   pd_minimal,
  output logic [SUSP_W-1:0]      suspend_level,
  input  wire uld_req_s          desc_req,
  output uld_rsp_s               desc_rsp
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [3:0]        cfg0_q;
  logic [SUSP_W-1:0] susp_q;
  logic              nv_cfg_q;
  logic [1:0]        cause_q, cause_d;
  uld_img_s          img_q;
  uld_link_e         st_q, st_d;
  logic              ack_q, nyet_q, wake_q;
  uld_rsp_s          rsp_q;
  logic [31:0]       rdata_q;

  wire link_pm_capability_bit  = cfg0_q[B_LINK_PM_CAPABILITY_BIT];
  wire rmt_wkp  = cfg0_q[B_RMT_WKP];
  wire self_pwr = cfg0_q[B_SELF_PWR];
  wire cust_en  = cfg0_q[B_CUST_EN];

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup  = psel & ~penable;
  wire access = psel & penable;
  wire wr     = access & pwrite;

  wire hit_cfg0 = (paddr == OFS_CFG0);
  wire hit_pm   = (paddr == OFS_PMCTL);
  wire hit_nv   = (paddr == OFS_NVSTAT);
  wire hit_link = (paddr == OFS_LINK);
  wire hit_ids  = (paddr == OFS_IDS);
  wire hit_dev0 = (paddr == OFS_DEV0);
  wire hit_dev1 = (paddr == OFS_DEV1);
  wire hit_dev2 = (paddr == OFS_DEV2);
  wire hit_cfgd = (paddr == OFS_CFGD);
  wire hit_tlen = (paddr == OFS_TLEN);
  wire mapped   = hit_cfg0 | hit_pm | hit_nv | hit_link | hit_ids | hit_dev0
                | hit_dev1 | hit_dev2 | hit_cfgd | hit_tlen;

  // Zero wait state: answer in the first access cycle
  assign pready  = access;
  assign pslverr = access & ~mapped;
  assign prdata  = rdata_q;

  // Merge the byte lanes enabled by pstrb into an old word
  function automatic logic [31:0] lanes(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  wire [31:0] w_ids  = {img_q.pid, img_q.vid};
  wire [31:0] w_dev0 = {img_q.dsub, img_q.dclass, img_q.bcd_usb};
  wire [31:0] w_dev1 = {img_q.iprod, img_q.imfr, img_q.mps0, img_q.dproto};
  wire [31:0] w_dev2 = {img_q.nif, img_q.clen, img_q.ncfg, img_q.iser};
  wire [31:0] w_cfgd = {img_q.maxpwr, img_q.attr, img_q.icfg, img_q.cval};
  wire [31:0] w_tlen = {16'h0000, img_q.tlen};
  wire [31:0] w_cfg0 = {28'h0000000, cfg0_q};
  wire [31:0] w_pm   = {{(32-SUSP_W){1'b0}}, susp_q};
  wire [31:0] w_nv   = {31'h00000000, nv_cfg_q};
  wire [31:0] w_link = {28'h0000000, cause_q, st_q};

  wire [31:0] rd_mux = hit_cfg0 ? w_cfg0 :
                       hit_pm   ? w_pm   :
                       hit_nv   ? w_nv   :
                       hit_link ? w_link :
                       hit_ids  ? w_ids  :
                       hit_dev0 ? w_dev0 :
                       hit_dev1 ? w_dev1 :
                       hit_dev2 ? w_dev2 :
                       hit_cfgd ? w_cfgd :
                       hit_tlen ? w_tlen : 32'h00000000;

  // Read data captured in the setup cycle; state is stable one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 32'h00000000;
    else if (setup)
      rdata_q <= rd_mux;
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  wire [31:0] cfg0_nx = lanes(w_cfg0, pwdata, pstrb);
  wire [31:0] pm_nx   = lanes(w_pm, pwdata, pstrb);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg0_q   <= 4'h0;
      susp_q   <= '0;
      nv_cfg_q <= 1'b0;
    end
    else if (wr)
    begin
      if (hit_cfg0)
        cfg0_q <= cfg0_nx[3:0];
      if (hit_pm)
        susp_q <= pm_nx[SUSP_W-1:0];
      if (hit_nv & pstrb[0])
        nv_cfg_q <= pwdata[0];
    end
  end

  // ----------------------------------------
  // Descriptor image from nonvolatile loader
  // ----------------------------------------
  wire [31:0] ids_nx  = lanes(w_ids, pwdata, pstrb);
  wire [31:0] dev0_nx = lanes(w_dev0, pwdata, pstrb);
  wire [31:0] dev1_nx = lanes(w_dev1, pwdata, pstrb);
  wire [31:0] dev2_nx = lanes(w_dev2, pwdata, pstrb);
  wire [31:0] cfgd_nx = lanes(w_cfgd, pwdata, pstrb);
  wire [31:0] tlen_nx = lanes(w_tlen, pwdata, pstrb);

  // Reset image holds the defaults so a partial load stays sane
  localparam uld_img_s IMG_RST = '{
    vid: DEF_VID, pid: DEF_PID, bcd_usb: BCD_USB2,
    dclass: DEF_CLASS, dsub: DEF_SUBCLASS, dproto: DEF_PROTO,
    mps0: MPS0_HS, imfr: DEF_STRIDX, iprod: DEF_STRIDX,
    iser: DEF_STRIDX, ncfg: DEF_ONE, clen: CFG_LEN, nif: DEF_ONE,
    cval: DEF_ONE, icfg: DEF_STRIDX, attr: DEF_ATTR,
    maxpwr: PWR_BUS2, tlen: TLEN_USB2};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      img_q <= IMG_RST;
    else if (wr)
    begin
      if (hit_ids)
        {img_q.pid, img_q.vid} <= ids_nx;
      if (hit_dev0)
        {img_q.dsub, img_q.dclass, img_q.bcd_usb} <= dev0_nx;
      if (hit_dev1)
        {img_q.iprod, img_q.imfr, img_q.mps0, img_q.dproto} <= dev1_nx;
      if (hit_dev2)
        {img_q.nif, img_q.clen, img_q.ncfg, img_q.iser} <= dev2_nx;
      if (hit_cfgd)
        {img_q.maxpwr, img_q.attr, img_q.icfg, img_q.cval} <= cfgd_nx;
      if (hit_tlen)
        img_q.tlen <= tlen_nx[15:0];
    end
  end

  // ----------------------------------------
  // Link power state machine
  // ----------------------------------------
  wire wake_evt  = rx_frame_pass | intr_ep_sched;
  wire l1_take   = lpm_l1_req & link_pm_capability_bit;
  wire l1_refuse = lpm_l1_req & ~link_pm_capability_bit;
  wire l1_wake   = (st_q == LNK_L1) & wake_evt & ~host_resume;
  wire l2_wake   = (st_q == LNK_L2) & wake_evt & rmt_wkp & ~host_resume;

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      LNK_L0:
        if (suspend_req)
          st_d = LNK_L2;
        else if (l1_take)
          st_d = LNK_L1;
      LNK_L1:
        if (host_resume | l1_wake)
          st_d = LNK_L0;
        else if (suspend_req)
          st_d = LNK_L2;
      LNK_L2:
        if (host_resume | l2_wake)
          st_d = LNK_L0;
      default:
        st_d = LNK_L0;
    endcase
  end

  // Wake cause: bit0 frame, bit1 interrupt endpoint; write 1 clears,
  // a new event in the same cycle wins over the clear
  wire [1:0] cause_set = (l1_wake | l2_wake) ? {intr_ep_sched, rx_frame_pass}
                                             : 2'b00;
  wire [1:0] cause_clr = (wr & hit_link & pstrb[0]) ? pwdata[3:2] : 2'b00;
  assign cause_d = (cause_q & ~cause_clr) | cause_set;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q    <= LNK_L0;
      ack_q   <= 1'b0;
      nyet_q  <= 1'b0;
      wake_q  <= 1'b0;
      cause_q <= 2'b00;
    end
    else
    begin
      st_q    <= st_d;
      ack_q   <= (st_q == LNK_L0) & l1_take & ~suspend_req;
      nyet_q  <= (st_q == LNK_L0) & l1_refuse & ~suspend_req;
      wake_q  <= l1_wake | l2_wake;
      cause_q <= cause_d;
    end
  end

  assign link_state    = st_q;
  assign lpm_ack       = ack_q;
  assign lpm_nyet      = nyet_q;
  assign remote_wake   = wake_q;
  // L1 keeps the clocks needed for a fast return to L0
  assign pd_minimal    = (st_q == LNK_L1);
  assign suspend_level = (st_q == LNK_L2) ? susp_q : '0;

  // ----------------------------------------
  // Descriptor read port
  // ----------------------------------------
  // Customization mode keeps the software image even when unconfigured
  wire use_def = ~nv_cfg_q & ~cust_en;

  logic [7:0] mux_data;
  logic       mux_err;

  // Speed is taken in the request cycle itself
  uld_desc_mux #(
    .SILICON_REV (SILICON_REV)
  ) u_mux (
    .img      (img_q),
    .use_def  (use_def),
    .speed    (bus_speed),
    .self_pwr (self_pwr),
    .rmt_wkp  (rmt_wkp),
    .is_cfg   (desc_req.is_cfg),
    .idx      (desc_req.idx),
    .data     (mux_data),
    .err      (mux_err)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rsp_q <= '0;
    else
    begin
      rsp_q.valid <= desc_req.valid;
      rsp_q.err   <= desc_req.valid & mux_err;
      rsp_q.data  <= desc_req.valid ? mux_data : ZERO8;
    end
  end

  assign desc_rsp = rsp_q;

endmodule

//--- uld_top_chk.sv
// Port-level checker for the link power and descriptor block.
// Assumes APB writes land when psel, penable and pready are high.
`timescale 1ns/1ps
module uld_top_chk
  import uld_pkg::*;
#(
  parameter int SUSP_W = 2
)(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire uld_speed_e        bus_speed,
  input wire logic              lpm_l1_req,
  input wire logic              suspend_req,
  input wire logic              host_resume,
  input wire logic              rx_frame_pass,
  input wire logic              intr_ep_sched,
  input wire logic              lpm_ack,
  input wire logic              lpm_nyet,
  input wire logic              remote_wake,
  input wire uld_link_e         link_state,
  input wire logic              pd_minimal,
  input wire logic [SUSP_W-1:0] suspend_level,
  input wire uld_req_s          desc_req,
  input wire uld_rsp_s          desc_rsp
);
  // ----------------------------------------
  // Shadow of the bits the rules depend on
  // ----------------------------------------
  logic              wr_cfg0;
  logic              wr_pm;
  logic              cap_q;
  logic [SUSP_W-1:0] depth_q;
  assign wr_cfg0 = psel && penable && pready && pwrite && paddr == OFS_CFG0 && pstrb[0];
  assign wr_pm   = psel && penable && pready && pwrite && paddr == OFS_PMCTL && pstrb[0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_q   <= 1'b0;
      depth_q <= '0;
    end
    else
    begin
      if (wr_cfg0)
        cap_q <= pwdata[B_LINK_PM_CAPABILITY_BIT];
      if (wr_pm)
        depth_q <= pwdata[SUSP_W-1:0];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  l1_accept_a: assert property (
    lpm_l1_req && !suspend_req && link_state == LNK_L0 && cap_q |=> lpm_ack && link_state == LNK_L1)
    else $error("L1 request not accepted");
  l1_refuse_a: assert property (
    lpm_l1_req && !suspend_req && link_state == LNK_L0 && !cap_q |=> lpm_nyet && link_state == LNK_L0)
    else $error("L1 request not refused");
  pd_minimal_a: assert property (pd_minimal == (link_state == LNK_L1))
    else $error("minimal power-down does not follow L1");
  l1_wake_a: assert property (
    link_state == LNK_L1 && (rx_frame_pass || intr_ep_sched) && !host_resume && !suspend_req
    |=> link_state == LNK_L0 && remote_wake) else $error("no wake from L1");
  l2_depth_a: assert property (
    suspend_level == ((link_state == LNK_L2) ? depth_q : '0)) else $error("suspend level wrong");
  rsp_timing_a: assert property (desc_rsp.valid == $past(desc_req.valid))
    else $error("descriptor answer not one cycle after request");
  dev_forced_a: assert property (
    desc_req.valid && !desc_req.is_cfg && desc_req.idx < 5'd2
    |=> desc_rsp.data == ($past(desc_req.idx[0]) ? DEV_TYPE : DEV_LEN)) else $error("bad header");
  cfg_type_a: assert property (
    desc_req.valid && desc_req.is_cfg && desc_req.idx == 5'd1 |=> desc_rsp.data == CFG_TYPE)
    else $error("configuration type not forced");
  ep0_size_a: assert property (
    desc_req.valid && !desc_req.is_cfg && desc_req.idx == 5'd7
    |=> desc_rsp.data == (($past(bus_speed) == SPD_SS) ? MPS0_SS : MPS0_HS)) else $error("bad mps");
  idx_range_a: assert property (
    desc_req.valid && desc_req.idx > (desc_req.is_cfg ? 5'd8 : 5'd17)
    |=> desc_rsp.err && desc_rsp.data == ZERO8) else $error("range error missing");
endmodule

bind uld_top uld_top_chk #(.SUSP_W(SUSP_W)) uld_top_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .bus_speed(bus_speed),
  .lpm_l1_req(lpm_l1_req), .suspend_req(suspend_req), .host_resume(host_resume),
  .rx_frame_pass(rx_frame_pass), .intr_ep_sched(intr_ep_sched), .lpm_ack(lpm_ack),
  .lpm_nyet(lpm_nyet), .remote_wake(remote_wake), .link_state(link_state),
  .pd_minimal(pd_minimal), .suspend_level(suspend_level), .desc_req(desc_req),
  .desc_rsp(desc_rsp));

//--- uld_host.sv
// Behavioural USB host: speed, link power requests, descriptor reads.
// Assumes callers use its tasks; all changes follow a rising edge.
`timescale 1ns/1ps
module uld_host
  import uld_pkg::*;
(
  input  wire logic pclk,
  output uld_speed_e bus_speed,
  output logic       lpm_l1_req,
  output logic       suspend_req,
  output logic       host_resume,
  output uld_req_s   desc_req
);
  initial
  begin
    bus_speed   = SPD_FS;
    lpm_l1_req  = 1'b0;
    suspend_req = 1'b0;
    host_resume = 1'b0;
    desc_req    = '0;
  end
  task automatic pulse(input int k);
    @(posedge pclk);
    lpm_l1_req  <= (k == 0);
    suspend_req <= (k == 1);
    host_resume <= (k == 2);
    @(posedge pclk);
    {lpm_l1_req, suspend_req, host_resume} <= 3'h0;
  endtask
  task automatic speed(input uld_speed_e s);
    @(posedge pclk);
    bus_speed <= s;
  endtask
  task automatic rd(input logic c, input logic [4:0] i);
    @(posedge pclk);
    desc_req <= '{1'b1, c, i};
  endtask
  // Idle request fields toggle so stale values are never trusted
  task automatic idle();
    @(posedge pclk);
    desc_req <= '{1'b0, ~desc_req.is_cfg, ~desc_req.idx};
  endtask
endmodule

//--- usb_lpm_and_descriptor_defaults_test.sv
// Self-checking bench: APB registers, descriptor defaults, link power.
// Assumes the checker is bound by its own file.
`timescale 1ns/1ps
module usb_lpm_and_descriptor_defaults_test;
  import uld_pkg::*;
  localparam logic [15:0] VID = 16'h2468;  // Arbitrary value
  localparam logic [15:0] PID = 16'h1357;  // Arbitrary value
  localparam logic [7:0]  REV = 8'h01;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_frame_pass = 0;
  logic intr_ep_sched = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, q;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr, lpm_l1_req, suspend_req, host_resume;
  logic        lpm_ack, lpm_nyet, remote_wake, pd_minimal;
  logic [1:0]  suspend_level, d;
  uld_speed_e  bus_speed;
  uld_link_e   link_state;
  uld_req_s    desc_req;
  uld_rsp_s    desc_rsp;
  int          n_errors = 0, comparisons = 0;
  logic [32:0] exp_r[$];
  logic [8:0]  exp_d[$];
  uld_speed_e  sp[3] = '{SPD_FS, SPD_HS, SPD_SS};

  uld_top #(.DEF_VID(VID), .DEF_PID(PID), .SILICON_REV(REV)) uld_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_speed(bus_speed), .lpm_l1_req(lpm_l1_req),
    .suspend_req(suspend_req), .host_resume(host_resume), .rx_frame_pass(rx_frame_pass),
    .intr_ep_sched(intr_ep_sched), .lpm_ack(lpm_ack), .lpm_nyet(lpm_nyet),
    .remote_wake(remote_wake), .link_state(link_state), .pd_minimal(pd_minimal),
    .suspend_level(suspend_level), .desc_req(desc_req), .desc_rsp(desc_rsp));
  uld_host uld_host_i (.pclk(pclk), .bus_speed(bus_speed), .lpm_l1_req(lpm_l1_req),
    .suspend_req(suspend_req), .host_resume(host_resume), .desc_req(desc_req));

  always #2 pclk = ~pclk;

  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    comparisons++;
    if (seen !== want)
    begin
      n_errors++;
      $display("BAD %0t saw %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v,
                     input logic [32:0] e);
    if (!w)
      exp_r.push_back(e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdx(input logic c, input logic [4:0] i, input logic [8:0] e);
    exp_d.push_back(e);
    uld_host_i.rd(c, i);
  endtask
  // Frame filter and interrupt scheduler events, one cycle each
  task automatic ev(input logic frame);
    @(posedge pclk);
    rx_frame_pass <= frame;
    intr_ep_sched <= !frame;
    @(posedge pclk);
    rx_frame_pass <= 1'b0;
    intr_ep_sched <= 1'b0;
  endtask
  task automatic lnk(input logic [1:0] st, input logic [2:0] pulses, input logic [1:0] lvl);
    #1;
    chk({25'h0, suspend_level, pd_minimal, link_state, lpm_ack, lpm_nyet, remote_wake},
        {25'h0, lvl, st == 2'd1, st, pulses});
  endtask
  function automatic logic [7:0] dflt(input logic c, input logic [4:0] i, input logic ss,
                                      input logic [2:0] c0);
    if (c)
      case (i)
        0: return 8'h09;
        1: return 8'h02;
        2: return ss ? 8'h39 : 8'h27;
        4, 5: return 8'h01;
        7: return {1'b1, c0[2], c0[1], 5'h0};
        8: return c0[2] ? 8'h01 : (ss ? 8'h70 : 8'hfa);
        default: return 8'h00;
      endcase
    case (i)
      0: return 8'h12;
      1, 17: return 8'h01;
      2: return ss ? 8'h00 : 8'h10;
      3: return ss ? 8'h03 : 8'h02;
      4, 6: return 8'hff;
      7: return ss ? 8'h09 : 8'h40;
      8: return VID[7:0];
      9: return VID[15:8];
      10: return PID[7:0];
      11: return PID[15:8];
      13: return REV;
      default: return 8'h00;
    endcase
  endfunction

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, exp_r.pop_front());
  always @(posedge pclk)
    if (desc_rsp.valid === 1'b1)
      chk({24'h0, desc_rsp.err, desc_rsp.data}, {24'h0, exp_d.pop_front()});

  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(64));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_CFG0, 0, 33'h0);
    apb(0, OFS_IDS, 0, {1'b0, PID, VID});
    apb(0, 8'h40, 0, {1'b1, 32'h0});
    // Defaults at every speed and power flag mix
    foreach (sp[s])
      for (int c0 = 0; c0 < 8; c0 += 2)
      begin
        apb(1, OFS_CFG0, c0, 0);
        uld_host_i.speed(sp[s]);
        for (int i = 0; i < 27; i++)
          rdx(i > 17, (i > 17) ? 5'(i - 18) : 5'(i), {1'b0, dflt(i > 17, 5'(i % 18), s == 2, 3'(c0))});
        uld_host_i.idle();
      end
    rdx(0, 5'd18, 9'h100);
    rdx(1, 5'd9, 9'h100);
    rdx(0, 5'(18 + $urandom % 14), 9'h100);
    uld_host_i.idle();
    // Loaded image; header fields stay forced
    r = $urandom;
    q = {8'($urandom), 8'($urandom), 8'($urandom), 8'h01};
    apb(1, OFS_NVSTAT, 1, 0);
    apb(1, OFS_DEV0, r, 0);
    apb(1, OFS_DEV2, {8'h01, 8'h09, 8'h01, r[7:0]}, 0);
    apb(1, OFS_CFGD, q, 0);
    apb(0, OFS_DEV0, 0, {1'b0, r});
    // Only the enabled byte lanes of the identifier word may change
    pstrb <= 4'h5;
    apb(1, OFS_IDS, ~r, 0);
    pstrb <= 4'hf;
    apb(0, OFS_IDS, 0, {1'b0, PID[15:8], ~r[23:16], VID[15:8], ~r[7:0]});
    for (int i = 0; i < 6; i++)
      rdx(0, 5'(i), {1'b0, (i < 2) ? dflt(0, 5'(i), 1, 0) : r[8*(i-2) +: 8]});
    rdx(0, 5'd7, 9'h009);
    rdx(0, 5'd12, 9'h000);
    rdx(0, 5'd16, {1'b0, r[7:0]});
    rdx(1, 5'd1, 9'h002);
    for (int i = 5; i < 9; i++)
      rdx(1, 5'(i), {1'b0, q[8*(i-5) +: 8]});
    uld_host_i.idle();
    // Customization keeps the image although nothing is configured
    apb(1, OFS_NVSTAT, 0, 0);
    apb(1, OFS_CFG0, 8, 0);
    rdx(0, 5'd4, {1'b0, r[23:16]});
    uld_host_i.idle();
    // Link power management
    uld_host_i.pulse(0);
    lnk(0, 3'b010, 0);
    d = 2'($urandom);
    apb(1, OFS_CFG0, 1, 0);
    apb(1, OFS_PMCTL, d, 0);
    uld_host_i.pulse(0);
    lnk(1, 3'b100, 0);
    ev(1);
    lnk(0, 3'b001, 0);
    apb(0, OFS_LINK, 0, 33'h4);
    apb(1, OFS_LINK, 4, 0);
    apb(0, OFS_LINK, 0, 33'h0);
    uld_host_i.pulse(0);
    lnk(1, 3'b100, 0);
    ev(0);
    lnk(0, 3'b001, 0);
    apb(0, OFS_LINK, 0, 33'h8);
    uld_host_i.pulse(1);
    lnk(2, 3'b000, d);
    ev(1);
    lnk(2, 3'b000, d);
    uld_host_i.pulse(2);
    lnk(0, 3'b000, 0);
    repeat (4) @(posedge pclk);
    wrap_up();
  end
endmodule
